// ### rail_ctrl_pkg.sv
// Purpose: constants for the four rail control registers
// Assumes: 8-bit register port, 100 MHz core_clk
// Notes: reset values are the factory image of each control register
// Functional notes
// - select 00 always uses normal voltage code
// - select 11 uses sleep code while pin low
// - sleep pin per rail fixed by factory
// - converter bit 1: 0 auto, 1 forced PWM
// - bit 0 low forces rail off
// - each enable bit acts on own rail only
// - sleep code register replaces normal code
package rail_ctrl_pkg;
  localparam int num_rails = 4;
  localparam logic [7:0] conv_e_offset = 8'h26;
  localparam logic [7:0] conv_f_offset = 8'h27;
  localparam logic [7:0] lin_b_offset = 8'h28;
  localparam logic [7:0] lin_c_offset = 8'h29;
  localparam int enable_bit = 0;
  localparam int mode_bit = 1;
  localparam int sel_lo = 4;
  localparam int sel_hi = 5;
  localparam logic [1:0] sel_off = 2'h0;
  localparam logic [1:0] sel_on = 2'h3;
  localparam logic [7:0] writable_mask = 8'h3f;
  localparam logic [7:0] conv_e_reset = 8'h0d;
  localparam logic [7:0] conv_f_reset = 8'h3d;
  localparam logic [7:0] lin_b_reset = 8'h0c;
  localparam logic [7:0] lin_c_reset = 8'h0c;
  // factory sleep pin choice per rail: 0 = pin one, 1 = pin two
  localparam logic [3:0] sleep_pin_map = 4'h0;
endpackage

// ### rail_code_select.sv
// Purpose: picks normal or sleep voltage code for one rail
// Assumes: inputs already synchronised to core_clk
// Notes: code output registered so the analog side sees a clean code; in_sleep is not
`timescale 1ns/1ns
`default_nettype none
module rail_code_select
  import rail_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] sleep_select,
  input wire logic sleep_pin,
  input wire logic [6:0] normal_code,
  input wire logic [6:0] sleep_code,
  output logic in_sleep,
  output logic [6:0] code_q
);
  logic [6:0] code_d;

  // reserved select codes fall back to normal code, the safe choice
  assign in_sleep = (sleep_select == sel_on) && !sleep_pin;
  assign code_d = in_sleep ? sleep_code : normal_code;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      code_q <= 7'h00;
    end else begin
      code_q <= code_d;
    end
  end
endmodule
`default_nettype wire

// ### regulator_rail_control_regs.sv
// Purpose: register bank for two converters and two linear regulators
// Assumes: a serial-bus front end delivers byte writes and reads
// Notes: sleep and control pins are asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none
module regulator_rail_control_regs
  import rail_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_hit,
  input wire logic sleep_request_pin_one,
  input wire logic sleep_request_pin_two,
  input wire logic [3:0] rail_pin_enable,
  input wire logic [27:0] normal_voltage_codes,
  input wire logic [27:0] sleep_voltage_codes,
  output logic [3:0] rail_on,
  output logic [3:0] rail_in_sleep,
  output logic [1:0] converter_pwm,
  output logic [27:0] rail_voltage_codes
);
  logic [7:0] ctrl_q [num_rails];
  logic [1:0] slp_meta_q, slp_sync_q;
  logic [3:0] pin_meta_q, pin_sync_q;
  logic [3:0] wr_hit;
  logic [1:0] rd_index;
  logic [3:0] rail_sleep_pin;

  // one compare serves every register decode
  function automatic logic addr_is(input logic [7:0] addr,
    input logic [7:0] offset);
    return addr == offset;
  endfunction

  // sleep select field of a control byte, for logic and checks alike
  function automatic logic [1:0] sel_field(input logic [7:0] ctrl);
    return ctrl[sel_hi:sel_lo];
  endfunction

  // address decode, one strobe per register
  assign wr_hit[0] = addr_is(reg_addr, conv_e_offset);
  assign wr_hit[1] = addr_is(reg_addr, conv_f_offset);
  assign wr_hit[2] = addr_is(reg_addr, lin_b_offset);
  assign wr_hit[3] = addr_is(reg_addr, lin_c_offset);
  assign reg_hit = |wr_hit;
  assign rd_index = reg_addr[1:0] + 2'h2;

  // two-stage synchronisers for all pin inputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slp_meta_q <= 2'h3;
      slp_sync_q <= 2'h3;
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      slp_meta_q <= {sleep_request_pin_two, sleep_request_pin_one};
      slp_sync_q <= slp_meta_q;
      pin_meta_q <= rail_pin_enable;
      pin_sync_q <= pin_meta_q;
    end
  end

  // control registers; bits 7:6 never stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q[0] <= conv_e_reset;
      ctrl_q[1] <= conv_f_reset;
      ctrl_q[2] <= lin_b_reset;
      ctrl_q[3] <= lin_c_reset;
    end else begin
      for (int i = 0; i < num_rails; i++) begin
        if (reg_write && wr_hit[i]) begin
          ctrl_q[i] <= reg_wdata & writable_mask;
        end
      end
    end
  end

  // readback; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_hit ? ctrl_q[rd_index] : 8'h00;
    end
  end

  // enable bit and synchronised pin must both be high, each rail independently
  // reserved middle bits written by host are stored, not checked
  genvar g;
  generate
    for (g = 0; g < num_rails; g++) begin : rail_gen
      assign rail_on[g] = ctrl_q[g][enable_bit] & pin_sync_q[g];
      assign rail_sleep_pin[g] = sleep_pin_map[g] ? slp_sync_q[1]
                                                 : slp_sync_q[0];
      rail_code_select u_sel (
        .core_clk(core_clk),
        .resetn(resetn),
        .sleep_select(sel_field(ctrl_q[g])),
        .sleep_pin(rail_sleep_pin[g]),
        .normal_code(normal_voltage_codes[g*7 +: 7]),
        .sleep_code(sleep_voltage_codes[g*7 +: 7]),
        .in_sleep(rail_in_sleep[g]),
        .code_q(rail_voltage_codes[g*7 +: 7])
      );
    end
  endgenerate

  // converter operating mode
  assign converter_pwm[0] = ctrl_q[0][mode_bit];
  assign converter_pwm[1] = ctrl_q[1][mode_bit];

  // checks on what the host reads back and what each rail is given

  // stored high bits always zero
  bits_zero_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    reg_hit |=> reg_rdata_q[7:6] == 2'h0)
    else $error("reserved bits read nonzero");

  // a written byte comes back masked on the read that follows it
  read_back_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[3]) ##1 (reg_addr == lin_c_offset && !reg_write)
      |=> reg_rdata_q == ($past(reg_wdata, 2) & writable_mask))
    else $error("readback mismatch");

  // same round trip on a converter register
  read_back_e_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[0]) ##1 (reg_addr == conv_e_offset && !reg_write)
      |=> reg_rdata_q == ($past(reg_wdata, 2) & writable_mask))
    else $error("readback e mismatch");

  // a cleared enable bit turns the rail off one cycle after the write
  enable_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[0] && !reg_wdata[enable_bit]) |=> !rail_on[0])
    else $error("rail e not forced off");

  // the override works the same on the second converter
  enable_f_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[1] && !reg_wdata[enable_bit]) |=> !rail_on[1])
    else $error("rail f not forced off");

  // and on the first linear regulator
  enable_b_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[2] && !reg_wdata[enable_bit]) |=> !rail_on[2])
    else $error("rail b not forced off");

  // and on the second linear regulator
  enable_c_off_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[3] && !reg_wdata[enable_bit]) |=> !rail_on[3])
    else $error("rail c not forced off");

  // mode bit reaches the converter unchanged
  mode_pwm_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[1]) |=>
      converter_pwm[1] == $past(reg_wdata[mode_bit]))
    else $error("converter f mode mismatch");

  // first converter mode, auto and forced alike
  mode_auto_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[0]) |=>
      converter_pwm[0] == $past(reg_wdata[mode_bit]))
    else $error("converter e mode mismatch");

  // a write to one rail leaves the others alone unless pins moved
  own_rail_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[2]) |=>
      $stable(rail_on[3]) || $changed(pin_sync_q))
    else $error("enable leaked to other rail");

  // same isolation seen from the converter side
  other_rail_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_write && wr_hit[0]) |=>
      $stable(rail_on[1]) || $changed(pin_sync_q))
    else $error("enable leaked to rail f");

  // select 00 keeps the normal code whatever the pins do
  normal_code_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[0]) == sel_off) |=>
      rail_voltage_codes[6:0] == $past(normal_voltage_codes[6:0]))
    else $error("rail e not at normal code");

  // likewise for the last rail, top slice of the code bus
  normal_code_c_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[3]) == sel_off) |=>
      rail_voltage_codes[27:21] == $past(normal_voltage_codes[27:21]))
    else $error("rail c not at normal code");

  // select 00 never reports sleep
  no_sleep_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[0]) == sel_off) |-> !rail_in_sleep[0])
    else $error("rail e asleep with select off");

  // select 11 and a low pin give the sleep code
  sleep_code_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[0]) == sel_on && !rail_sleep_pin[0]) |=>
      rail_voltage_codes[6:0] == $past(sleep_voltage_codes[6:0]))
    else $error("rail e not at sleep code");

  // sleep code on a linear regulator too
  sleep_code_b_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[2]) == sel_on && !rail_sleep_pin[2]) |=>
      rail_voltage_codes[20:14] == $past(sleep_voltage_codes[20:14]))
    else $error("rail b not at sleep code");

  // select 11 with the pin high stays on the normal code
  awake_code_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (sel_field(ctrl_q[1]) == sel_on && rail_sleep_pin[1]) |=>
      rail_voltage_codes[13:7] == $past(normal_voltage_codes[13:7]))
    else $error("rail f left normal code");

  // factory map sends rail f to pin one only
  pin_map_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rail_in_sleep[1] |-> !slp_sync_q[0] && sel_field(ctrl_q[1]) == sel_on)
    else $error("wrong sleep pin used");
endmodule
`default_nettype wire

// ### host_model.sv
// Purpose: host side model that keeps select codes and middle bits legal; bits 7:6 pass through
// Assumes: bench drives req fields just after the rising edge
// Notes: pass-through so write timing is the bench's own
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic req,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_value,
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  logic lin;
  logic [1:0] sel;
  // reserved select codes become 00 so they never reach the bus
  assign sel = (req_value[5:4] == 2'h3) ? 2'h3 : 2'h0;
  assign lin = req_addr[3];
  assign reg_write = req;
  assign reg_addr = req_addr;
  // fixed patterns in the reserved middle bits
  assign reg_wdata = lin ? {req_value[7:6], sel, 3'h6, req_value[0]}
    : {req_value[7:6], sel, 2'h3, req_value[1:0]};
endmodule
`default_nettype wire

// ### regulator_rail_control_regs_tb.sv
// Purpose: self-checking bench for the rail control register bank
// Assumes: host_model keeps select codes and middle bits legal; bits 7:6 pass through
// Notes: pins pass two sync flops, codes one flop more
`timescale 1ns/1ns
`default_nettype none
module regulator_rail_control_regs_tb;
  import rail_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] v; logic [7:0] r;} row_type;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic [7:0] req_addr = 8'h26;
  logic [7:0] req_value = 8'h00;
  logic pin_one = 1'b1;
  logic pin_two = 1'b1;
  logic [3:0] pin_en = 4'hf;
  logic reg_write, reg_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [3:0] rail_on, rail_in_sleep;
  logic [1:0] converter_pwm;
  logic [27:0] rail_voltage_codes;
  logic [27:0] nc = 28'h1234567;
  logic [27:0] sc = 28'h7654321;
  int bad_count = 0;
  int checks = 0;
  // address, value asked for, value read back
  row_type rows [5] = '{'{8'h26, 8'hc0, 8'h0c}, '{8'h27, 8'h33, 8'h3f},
    '{8'h28, 8'h31, 8'h3d}, '{8'h29, 8'h10, 8'h0c}, '{8'h30, 8'h3f, 8'h00}};
  row_type rst_rows [4] = '{'{conv_e_offset, 8'h00, conv_e_reset},
    '{conv_f_offset, 8'h00, conv_f_reset}, '{lin_b_offset, 8'h00, lin_b_reset},
    '{lin_c_offset, 8'h00, lin_c_reset}};
  host_model host_model_i (.req(req), .req_addr(req_addr),
    .req_value(req_value), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  regulator_rail_control_regs regulator_rail_control_regs_i (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_hit(reg_hit), .sleep_request_pin_one(pin_one),
    .sleep_request_pin_two(pin_two), .rail_pin_enable(pin_en),
    .normal_voltage_codes(nc), .sleep_voltage_codes(sc), .rail_on(rail_on),
    .rail_in_sleep(rail_in_sleep), .converter_pwm(converter_pwm),
    .rail_voltage_codes(rail_voltage_codes));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [27:0] e,
    input logic [27:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // write is taken at the edge where req is high
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    req <= 1'b1;
    req_addr <= a;
    req_value <= v;
    @(posedge core_clk);
    req <= 1'b0;
  endtask
  // read data is registered one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req_addr <= a;
    @(posedge core_clk);
    #1 d = reg_rdata_q;
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog so a hang still reaches the verdict
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].v);
      rd(rows[i].a, d);
      chk("rdata", rows[i].r, d);
      chk("hit", rows[i].a inside {[8'h26:8'h29]}, reg_hit);
    end
    repeat (3) @(posedge core_clk);
    #1 chk("rail_on", 4'h6, rail_on);
    chk("pwm", 2'h2, converter_pwm);
    @(posedge core_clk) pin_one <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 chk("sleep", 4'h6, rail_in_sleep);
    chk("codes", (nc & ~28'h1fff80) | (sc & 28'h1fff80),
      rail_voltage_codes);
    // pin two is unused under the factory map; pins alone cannot enable
    @(posedge core_clk);
    pin_one <= 1'b1;
    pin_two <= 1'b0;
    pin_en <= 4'h9;
    repeat (5) @(posedge core_clk);
    #1 chk("sleep_two", 4'h0, rail_in_sleep);
    chk("codes_awake", nc, rail_voltage_codes);
    chk("rail_off", 4'h0, rail_on);
    // every rail enabled, both converters forced, all rails asleep
    wr(conv_e_offset, 8'h33);
    wr(lin_c_offset, 8'h31);
    rd(conv_e_offset, d);
    chk("rdata_e", 8'h3f, d);
    @(posedge core_clk);
    pin_one <= 1'b0;
    pin_two <= 1'b1;
    pin_en <= 4'hf;
    repeat (5) @(posedge core_clk);
    #1 chk("rail_on_all", 4'hf, rail_on);
    chk("pwm_all", 2'h3, converter_pwm);
    chk("sleep_all", 4'hf, rail_in_sleep);
    chk("codes_sleep", sc, rail_voltage_codes);
    wr(conv_e_offset, 8'h32);
    #1 chk("rail_e_off", 4'he, rail_on);
    // second reset in mid-run restores the factory image
    @(posedge core_clk) resetn <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk("rst_on", 4'h0, rail_on);
    @(posedge core_clk) resetn <= 1'b1;
    foreach (rst_rows[i]) begin
      rd(rst_rows[i].a, d);
      chk("reset", rst_rows[i].r, d);
    end
    #1 chk("rst_sleep", 4'h2, rail_in_sleep);
    chk("rst_on_pins", 4'h3, rail_on);
    chk("rst_codes", (nc & ~28'h3f80) | (sc & 28'h3f80),
      rail_voltage_codes);
    tally_and_finish();
  end
endmodule
`default_nettype wire
